// File: hw/sop_params.svh
// Purpose: Timing counts and field constants for the slave program port.
// Assumes: i_clk is the device oscillator, one period per cycle.
// Notes: All delay, valid and hold figures are oscillator periods.
`ifndef SOP_PARAMS_SVH
`define SOP_PARAMS_SVH

`define SOP_DUMP_VALID_MAX 8'd50
`define SOP_VERIFY_VALID_MAX 8'd220
`define SOP_VERIFY_HOLD_MIN 8'd50
`define SOP_ADDR_STEP 16'h0002
`define SOP_ADDR_RESET 16'h0000
`define SOP_CMD_DUMP 16'h0001
`define SOP_DUMP_DELAY 8'd4
`define SOP_VERIFY_DELAY 8'd8
`define SOP_FIFO_DEPTH 8
`define SOP_FIFO_WIDTH 16

`endif

// File: hw/sop_pkg.sv
// Purpose: Types for the slave program port.
// Assumes: Constants come from sop_params.svh.
// Notes: States are one-hot.
package sop_pkg;
  typedef enum logic [4:0] {
    SOP_IDLE = 5'b00001,
    SOP_LATCHED = 5'b00010,
    SOP_PULSE = 5'b00100,
    SOP_VERIFY = 5'b01000,
    SOP_DONE = 5'b10000
  } sop_state_t;
endpackage : sop_pkg

// File: hw/sop_fifo.sv
// Purpose: Small valid/ready FIFO for dumped words.
// Assumes: Single clock, asynchronous active-high reset.
// Notes: Width and depth are parameters.
`timescale 1ns/1ns
module sop_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  always_comb begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  assign o_in_ready = (count != FULL);
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
endmodule : sop_fifo

// File: hw/sop_port.sv
// Purpose: Slave-mode one-time-programmable word program and dump port.
// Assumes: Strobes are asynchronous pins; clock is the oscillator.
// Notes: Dumped words queue in a FIFO before reaching the port pins.
`timescale 1ns/1ns
`include "sop_params.svh"

// Function
// - A dumped word is on ports 3 and 4 within 50 periods of the pulse fall.
// - A dump pulse lasts 50 periods; real programming uses quick-pulse.
// - The verify flag stays stable 50 periods after the step strobe falls.
// - The verify flag is valid within 220 periods of the pulse rise.
// - Each step pulse advances the address by two bytes.
module sop_port (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_address_latch_strobe_n,
  input wire logic i_write_pulse_strobe_n,
  input wire logic i_address_step_strobe_n,
  input wire logic [15:0] i_port_data,
  output logic [15:0] o_port_data,
  output logic [15:0] o_port_oe,
  output logic o_verify_pass_flag,
  output logic [15:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  output logic o_mem_write,
  input wire logic [15:0] i_mem_rdata
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] strobe_last;
  logic [15:0] data_a;
  logic [15:0] data_b;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
      strobe_last <= 3'h7;
      data_a <= 16'h0000;
      data_b <= 16'h0000;
    end else begin
      sync_a <= {i_address_step_strobe_n, i_write_pulse_strobe_n,
                 i_address_latch_strobe_n};
      sync_b <= sync_a;
      strobe_last <= sync_b;
      data_a <= i_port_data;
      data_b <= data_a;
    end
  end

  logic latch_rise;
  logic pulse_fall;
  logic pulse_rise;
  logic step_fall;
  always_comb begin
    latch_rise = sync_b[0] && !strobe_last[0];
    pulse_fall = !sync_b[1] && strobe_last[1];
    pulse_rise = sync_b[1] && !strobe_last[1];
    step_fall = !sync_b[2] && strobe_last[2];
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  sop_pkg::sop_state_t state;
  sop_pkg::sop_state_t next_state;
  logic [15:0] addr;
  logic [15:0] next_addr;
  logic dump_mode;
  logic next_dump_mode;
  logic [7:0] timer;
  logic [7:0] next_timer;
  logic verify;
  logic next_verify;
  logic [15:0] wdata;
  logic [15:0] next_wdata;
  logic wr_pulse;
  logic next_wr_pulse;
  logic dump_push;
  logic next_dump_push;
  logic [15:0] dump_word;
  logic [15:0] next_dump_word;
  logic fifo_ready;
  logic fifo_valid;
  logic [15:0] fifo_word;
  logic drive;
  logic next_drive;
  logic [15:0] pins;
  logic [15:0] next_pins;
  logic step_wait;
  logic next_step_wait;
  logic [7:0] hold;
  logic [7:0] next_hold;
  logic ver_res;
  logic next_ver_res;
  logic ver_due;
  logic next_ver_due;
  logic busy;

  always_comb begin
    next_state = state;
    next_addr = addr;
    next_dump_mode = dump_mode;
    next_timer = timer;
    next_verify = verify;
    next_wdata = wdata;
    next_wr_pulse = 1'b0;
    next_dump_push = 1'b0;
    next_dump_word = dump_word;
    next_step_wait = step_wait;
    next_hold = hold;
    next_ver_res = ver_res;
    next_ver_due = ver_due;
    busy = (state == sop_pkg::SOP_PULSE) ||
           (state == sop_pkg::SOP_VERIFY && timer != 8'h01);
    if (timer != 8'h00) begin
      next_timer = timer - 8'h01;
    end
    // Step waits until the word in flight is written and read back
    if ((step_fall || step_wait) && !busy) begin
      next_addr = addr + `SOP_ADDR_STEP;
      next_step_wait = 1'b0;
    end else if (step_fall) begin
      next_step_wait = 1'b1;
    end
    // Flag frozen for the hold time after each step fall
    if (step_fall) begin
      next_hold = `SOP_VERIFY_HOLD_MIN;
    end else if (hold != 8'h00) begin
      next_hold = hold - 8'h01;
    end
    if (ver_due && hold == 8'h00 && !step_fall) begin
      next_verify = ver_res;
      next_ver_due = 1'b0;
    end
    case (state)
      sop_pkg::SOP_IDLE: begin
        if (latch_rise) begin
          next_dump_mode = (data_b == `SOP_CMD_DUMP);
          next_state = sop_pkg::SOP_LATCHED;
        end
      end
      sop_pkg::SOP_LATCHED: begin
        if (latch_rise) begin
          next_addr = data_b;
        end else if (pulse_fall) begin
          next_wdata = data_b;
          next_timer = dump_mode ? `SOP_DUMP_DELAY : 8'h00;
          next_state = sop_pkg::SOP_PULSE;
        end
      end
      sop_pkg::SOP_PULSE: begin
        if (dump_mode && timer == 8'h01 && fifo_ready) begin
          next_dump_word = i_mem_rdata;
          next_dump_push = 1'b1;
        end
        if (pulse_rise) begin
          next_wr_pulse = !dump_mode;
          next_timer = `SOP_VERIFY_DELAY;
          next_state = sop_pkg::SOP_VERIFY;
        end
      end
      sop_pkg::SOP_VERIFY: begin
        if (timer == 8'h01) begin
          next_ver_res = dump_mode || (i_mem_rdata == wdata);
          next_ver_due = 1'b1;
          next_state = sop_pkg::SOP_DONE;
        end
      end
      sop_pkg::SOP_DONE: begin
        // Flag held until the next verify result is released
        if (pulse_fall) begin
          next_wdata = data_b;
          next_timer = dump_mode ? `SOP_DUMP_DELAY : 8'h00;
          next_state = sop_pkg::SOP_PULSE;
        end else if (latch_rise) begin
          next_state = sop_pkg::SOP_IDLE;
        end
      end
      default: next_state = sop_pkg::SOP_IDLE;
    endcase
  end

  always_comb begin
    next_drive = dump_mode && (state == sop_pkg::SOP_PULSE ||
                               state == sop_pkg::SOP_VERIFY ||
                               state == sop_pkg::SOP_DONE);
    next_pins = fifo_valid ? fifo_word : pins;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= sop_pkg::SOP_IDLE;
      addr <= `SOP_ADDR_RESET;
      dump_mode <= 1'b0;
      timer <= 8'h00;
      verify <= 1'b0;
      wdata <= 16'h0000;
      wr_pulse <= 1'b0;
      dump_push <= 1'b0;
      dump_word <= 16'h0000;
      drive <= 1'b0;
      pins <= 16'h0000;
      step_wait <= 1'b0;
      hold <= 8'h00;
      ver_res <= 1'b0;
      ver_due <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      dump_mode <= next_dump_mode;
      timer <= next_timer;
      verify <= next_verify;
      wdata <= next_wdata;
      wr_pulse <= next_wr_pulse;
      dump_push <= next_dump_push;
      dump_word <= next_dump_word;
      drive <= next_drive;
      pins <= next_pins;
      step_wait <= next_step_wait;
      hold <= next_hold;
      ver_res <= next_ver_res;
      ver_due <= next_ver_due;
    end
  end

  // ----------------------------------------------------------------
  // Dump buffer
  // ----------------------------------------------------------------
  sop_fifo #(
    .WIDTH(`SOP_FIFO_WIDTH),
    .DEPTH(`SOP_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(dump_push),
    .o_in_ready(fifo_ready),
    .i_in_data(dump_word),
    .o_out_valid(fifo_valid),
    .i_out_ready(1'b1),
    .o_out_data(fifo_word)
  );

  assign o_port_data = pins;
  assign o_port_oe = {16{drive}};
  assign o_verify_pass_flag = verify;
  assign o_mem_addr = addr;
  assign o_mem_wdata = wdata;
  assign o_mem_write = wr_pulse;
endmodule : sop_port

// File: tb/sop_port_checker.sv
// Purpose: Port checker for the slave program port.
// Assumes: Bound to sop_port, one clock domain.
// Notes: Bounds are oscillator periods.
`timescale 1ns/1ns
module sop_port_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_write_pulse_strobe_n,
  input wire logic i_address_step_strobe_n,
  input wire logic [15:0] o_port_data,
  input wire logic [15:0] o_port_oe,
  input wire logic o_verify_pass_flag,
  input wire logic [15:0] o_mem_addr,
  input wire logic [15:0] o_mem_wdata,
  input wire logic o_mem_write,
  input wire logic [15:0] i_mem_rdata
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [5:0] since_step;
  logic [15:0] step_base;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      since_step <= 6'h0;
      step_base <= 16'h0;
    end else if ($fell(i_address_step_strobe_n)) begin
      since_step <= 6'h1;
      step_base <= o_mem_addr + 16'h2;
    end else if (since_step != 6'h0 && since_step < 6'h32) begin
      since_step <= since_step + 6'h1;
    end else begin
      since_step <= 6'h0;
    end
  end
  logic wr_seen;
  logic ver_exp;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_seen <= 1'b0;
      ver_exp <= 1'b0;
    end else begin
      wr_seen <= o_mem_write;
      if (wr_seen) begin
        ver_exp <= (i_mem_rdata == o_mem_wdata);
      end
    end
  end
  a_dump_valid: assert property ($fell(i_write_pulse_strobe_n) ##6
    o_port_oe == 16'hffff |-> ##[0:44] o_port_data == i_mem_rdata)
    else $error("dump word late");
  a_step_addr: assert property ($fell(i_address_step_strobe_n) |=> ##[0:10]
    o_mem_addr == step_base) else $error("address step wrong");
  a_verify_hold: assert property (since_step != 6'h0 |->
    $stable(o_verify_pass_flag)) else $error("verify flag moved");
  a_verify_valid: assert property ($rose(i_write_pulse_strobe_n) &&
    o_port_oe == 16'h0 |-> ##[1:220]
    o_verify_pass_flag == ver_exp)
    else $error("verify flag late");
  a_write_after_pulse: assert property ($rose(i_write_pulse_strobe_n) &&
    o_port_oe == 16'h0 |-> ##[1:12] o_mem_write) else $error("no write");
  a_write_single: assert property (o_mem_write |=> !o_mem_write)
    else $error("write pulse too long");
  a_no_dump_write: assert property (o_port_oe != 16'h0 |-> !o_mem_write)
    else $error("write in dump mode");
  a_oe_whole: assert property (o_port_oe == 16'h0 ||
    o_port_oe == 16'hffff) else $error("partial port drive");
endmodule : sop_port_checker

bind sop_port sop_port_checker chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_write_pulse_strobe_n(i_write_pulse_strobe_n),
  .i_address_step_strobe_n(i_address_step_strobe_n),
  .o_port_data(o_port_data), .o_port_oe(o_port_oe),
  .o_verify_pass_flag(o_verify_pass_flag), .o_mem_addr(o_mem_addr),
  .o_mem_wdata(o_mem_wdata), .o_mem_write(o_mem_write),
  .i_mem_rdata(i_mem_rdata));

// File: tb/sop_write_pulse_strobe_model.sv
// Purpose: External programmer model for strobes and port pins.
// Assumes: Tasks are called by the bench after reset.
// Notes: Intervals are whole oscillator periods.
`timescale 1ns/1ns
module sop_write_pulse_strobe_model (
  input wire logic i_clk,
  output logic o_latch_n,
  output logic o_pulse_n,
  output logic o_step_n,
  output logic [15:0] o_data
);
  // ----------------------------------------
  // Strobe tasks
  // ----------------------------------------
  initial begin
    o_latch_n = 1'b1;
    o_pulse_n = 1'b1;
    o_step_n = 1'b1;
    o_data = 16'h0;
  end
  task automatic settle;
    repeat (1100) @(posedge i_clk);
  endtask : settle
  task automatic latch(input logic [15:0] d);
    repeat (220) @(posedge i_clk);
    o_data <= d;
    o_latch_n <= 1'b0;
    repeat (50) @(posedge i_clk);
    o_latch_n <= 1'b1;
    repeat (220) @(posedge i_clk);
  endtask : latch
  task automatic pulse(input logic [15:0] d, input int w);
    o_data <= d;
    o_pulse_n <= 1'b0;
    repeat (w) @(posedge i_clk);
    o_pulse_n <= 1'b1;
  endtask : pulse
  task automatic step;
    o_step_n <= 1'b0;
    repeat (240) @(posedge i_clk);
    o_step_n <= 1'b1;
  endtask : step
endmodule : sop_write_pulse_strobe_model

// File: tb/tb_slave_otp_program_port.sv
// Purpose: Self-checking bench for the slave program port.
// Assumes: The programmer model drives strobes and pins.
// Notes: Memory is a small word array.
`timescale 1ns/1ns
module tb_slave_otp_program_port;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic ale_n, pls_n, stp_n, mem_write, flag;
  logic [15:0] drv, pins, pdata, oe, addr, wdata, rdata;
  logic [15:0] mem [0:255];
  int num_errors = 0;
  int checks = 0;
  always #10 i_clk = ~i_clk;
  assign pins = (oe & pdata) | (~oe & drv);
  assign rdata = mem[addr[8:1]];
  always @(posedge i_clk) if (mem_write) mem[addr[8:1]] <= wdata;
  sop_port dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_address_latch_strobe_n(ale_n), .i_write_pulse_strobe_n(pls_n),
    .i_address_step_strobe_n(stp_n), .i_port_data(pins),
    .o_port_data(pdata), .o_port_oe(oe), .o_verify_pass_flag(flag),
    .o_mem_addr(addr), .o_mem_wdata(wdata), .o_mem_write(mem_write),
    .i_mem_rdata(rdata));
  sop_write_pulse_strobe_model write_pulse_strobe_u (.i_clk(i_clk), .o_latch_n(ale_n),
    .o_pulse_n(pls_n), .o_step_n(stp_n), .o_data(drv));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic do_reset;
    i_sys_rst <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk(addr, 16'h0);
    chk(oe, 16'h0);
    chk({15'h0, flag}, 16'h0);
    i_sys_rst <= 1'b0;
    write_pulse_strobe_u.settle();
    $display("reset test done");
  endtask : do_reset
  task automatic test_program;
    write_pulse_strobe_u.latch(16'h0000);
    write_pulse_strobe_u.latch(16'h0010);
    write_pulse_strobe_u.pulse(16'ha5c3, 100);
    write_pulse_strobe_u.step();
    chk(mem[8], 16'ha5c3);
    chk({15'h0, flag}, 16'h1);
    write_pulse_strobe_u.pulse(16'h5a3c, 100);
    write_pulse_strobe_u.step();
    chk(mem[9], 16'h5a3c);
    chk(addr, 16'h0014);
    chk({15'h0, flag}, 16'h1);
    $display("program test done");
  endtask : test_program
  task automatic test_dump;
    do_reset();
    write_pulse_strobe_u.latch(16'h0001);
    write_pulse_strobe_u.latch(16'h0010);
    write_pulse_strobe_u.pulse(16'h0000, 50);
    chk(pdata, 16'ha5c3);
    chk(oe, 16'hffff);
    write_pulse_strobe_u.step();
    write_pulse_strobe_u.pulse(16'h0000, 50);
    chk(pdata, 16'h5a3c);
    $display("dump test done");
  endtask : test_dump
  initial begin
    do_reset();
    test_program();
    test_dump();
    complete_run();
  end
  initial begin
    #400000;
    num_errors++;
    complete_run();
  end
endmodule : tb_slave_otp_program_port
